// ### sim/asis_checker.sv
// concurrent checks on the ports of the sequence input select block
`timescale 1ns/1ps
module asis_checker (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire step_valid_i,
    input wire [2:0] step_i,
    input wire [1:0] step_input_select_o
);
    reg [31:0] sh_ff;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire [31:0] bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & 32'h3333_3333;
    wire [1:0] exp_pin = sh_ff[{step_i, 2'b00} +: 2];
    // shadow of the select register; reserved pairs never enter it
    always @(posedge clk_i) begin
        if (rst_i)
            sh_ff <= 32'h0;
        else if (req && wb_we_i && wb_adr_i == 8'h40)
            sh_ff <= (sh_ff & ~bm) | (wb_dat_i & bm);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_answer_time: assert property (req |=> wb_ack_o != wb_err_o) else $error("no single answer");
    chk_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o) else $error("stray answer");
    chk_unmapped_err: assert property (req && wb_adr_i != 8'h40 && wb_adr_i != 8'h48 && wb_adr_i != 8'h4c
        |=> wb_err_o) else $error("no err on unmapped");
    chk_read_back: assert property (req && !wb_we_i && wb_adr_i == 8'h40 |=> wb_dat_o == sh_ff) else $error("bad readback");
    chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
    chk_step_pin: assert property (step_valid_i |-> ##2 step_input_select_o == $past(exp_pin, 2)) else $error("bad pin");
    chk_pin_hold: assert property (!step_valid_i |-> ##2 $stable(step_input_select_o)) else $error("pin moved");
endmodule // asis_checker
bind asis_top asis_checker i_asis_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .step_valid_i(step_valid_i), .step_i(step_i),
    .step_input_select_o(step_input_select_o));

// ### sim/asis_seq_model.sv
// sample sequencer model that walks sequence zero through its eight steps
`timescale 1ns/1ps
module asis_seq_model (
    input wire clk_i,
    input wire run_i,
    output reg step_valid_o,
    output reg [2:0] step_o
);
    reg [4:0] cnt_ff;
    initial begin
        step_valid_o = 1'b0;
        step_o = 3'h0;
    end
    // each step stands four cycles; idle step lines toggle so nothing may rely on them
    always @(posedge clk_i) begin
        cnt_ff <= run_i ? cnt_ff + 5'h1 : 5'h0;
        step_valid_o <= run_i;
        step_o <= run_i ? cnt_ff[4:2] : ~step_o;
    end
endmodule // asis_seq_model

// ### sim/tb_asis_top.sv
// testbench for the sequence input select block
`timescale 1ns/1ps
module tb_asis_top;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0, stb = 0, we = 0, run = 0, e;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, q, pat;
    logic [1:0] hv = 2'h0;
    logic [2:0] hs [0:1];
    wire [31:0] rdat;
    wire ack, err, sv;
    wire [2:0] st;
    wire [1:0] pin, wpin;
    wire wbusy;
    int nb;
    int n_errors = 0, n_compared = 0, ticks = 0, i;
    // rows: we, address, lanes, write data, expected read data, expected err
    logic [77:0] rows [0:8] = '{{1'b0, 8'h40, 4'hf, 32'h0, 32'h0, 1'b0}, {1'b1, 8'h40, 4'hf, ~32'h0, 32'h0, 1'b0},
        {1'b0, 8'h40, 4'hf, 32'h0, 32'h3333_3333, 1'b0}, {1'b1, 8'h40, 4'h5, 32'h00aa_00bb, 32'h0, 1'b0},
        {1'b0, 8'h40, 4'hf, 32'h0, 32'h3322_3333, 1'b0}, {1'b1, 8'h4c, 4'hf, ~32'h0, 32'h0, 1'b0},
        {1'b0, 8'h10, 4'hf, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h40, 4'hf, 32'h0312_0321, 32'h0, 1'b0},
        {1'b0, 8'h40, 4'hf, 32'h0, 32'h0312_0321, 1'b0}};
    asis_top i_asis_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .step_valid_i(sv), .step_i(st), .step_input_select_o(pin), .seq_input_select_o(wpin), .seq_busy_o(wbusy));
    asis_seq_model i_asis_seq_model (.clk_i(clk_i), .run_i(run), .step_valid_o(sv), .step_o(st));
    initial forever #5 clk_i = ~clk_i;
    task check(input [31:0] seen, input [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; request stands until the edge that samples the answer
    task wb(input w, input [7:0] a, input [3:0] s, input [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do @(posedge clk_i); while (!(ack || err));
        q = rdat;
        e = err;
        {cyc, stb} <= 2'b00;
    endtask
    task complete_run;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, well above the hundred or so cycles the run needs
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 3000) begin
            n_errors++;
            complete_run;
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        for (i = 0; i < 9; i++) begin
            wb(rows[i][77], rows[i][76:69], rows[i][68:65], rows[i][64:33]);
            check(q, rows[i][32:1]);
            check(32'(e), 32'(rows[i][0]));
            $display("row %0d done", i);
        end
        // software read-modify-write that keeps the reserved pairs as read
        wb(0, 8'h40, 4'hf, 0);
        pat = (q & ~32'h3000_0000) | 32'h1000_0000;
        wb(1, 8'h40, 4'hf, pat);
        wb(0, 8'h40, 4'hf, 0);
        check(q, 32'h1312_0321);
        // pin seen at an edge belongs to the step sampled two edges earlier
        run <= 1;
        for (i = 0; i < 36; i++) begin
            @(posedge clk_i);
            if (hv[1] === 1'b1) check(32'(pin), 32'(pat[{hs[1], 2'b00} +: 2]));
            hv = {hv[0], sv};
            hs[1] = hs[0];
            hs[0] = st;
        end
        $display("step walk done");
        // internal walker: start with last step three, three busy cycles, ends on that step's field
        run <= 0;
        wb(1, 8'h48, 4'h1, 32'h0000_0021);
        nb = 0;
        repeat (10) begin
            @(posedge clk_i);
            if (wbusy === 1'b1) nb++;
        end
        check(nb, 3);
        check(32'(wbusy), 32'h0);
        check(32'(wpin), 32'(pat[9:8]));
        wb(0, 8'h48, 4'hf, 0);
        check(q, 32'h0000_0020);
        wb(0, 8'h4c, 4'hf, 0);
        check(q, 32'h0000_0320);
        $display("walker test done");
        rst_i <= 1;
        run <= 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 8'h40, 4'hf, 0);
        check(q, 32'h0);
        check(32'(pin), 32'h0);
        $display("reset test done");
        complete_run;
    end
endmodule // tb_asis_top

// ### verilog/asis_field_mux.v
// picks the selection field that belongs to one sample step
`timescale 1ns/1ps
`include "asis_map.vh"
module asis_field_mux (
    input wire clk_i,
    input wire rst_i,
    input wire [31:0] select_i,
    input wire [`ASIS_STEP_W-1:0] step_i,
    output reg [`ASIS_FIELD_W-1:0] pin_o
);
    wire [`ASIS_FIELD_W-1:0] field [0:`ASIS_STEPS-1];
    genvar g;
    // one field every four bits, step one at the bottom
    generate
        for (g = 0; g < `ASIS_STEPS; g = g + 1) begin : g_field
            assign field[g] = select_i[g*`ASIS_FIELD_PITCH +: `ASIS_FIELD_W];
        end
    endgenerate
    // field value is the pin number itself, no remapping
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= {`ASIS_FIELD_W{1'b0}};
        end else begin
            pin_o <= field[step_i]; // R9
        end
    end
endmodule // asis_field_mux

// ### verilog/asis_map.vh
// register map, field layout and constants of the sequence input select block
`ifndef ASIS_MAP_VH
`define ASIS_MAP_VH
`define ASIS_OFS_SELECT 8'h40
`define ASIS_OFS_STEP_CTRL 8'h48
`define ASIS_OFS_STEP_STATUS 8'h4c
`define ASIS_SELECT_RESET 32'h0000_0000
`define ASIS_SELECT_WMASK 32'h3333_3333
`define ASIS_FIELD_W 2
`define ASIS_FIELD_PITCH 4
`define ASIS_STEPS 8
`define ASIS_STEP_W 3
`define ASIS_STEP_FIRST 3'h0
`define ASIS_STEP_LAST 3'h7
`define ASIS_CTRL_RUN 0
`define ASIS_CTRL_LAST_LSB 4
`define ASIS_CTRL_LAST_MSB 6
`define ASIS_STAT_BUSY 0
`define ASIS_STAT_STEP_LSB 4
`define ASIS_STAT_STEP_MSB 6
`define ASIS_STAT_SEL_LSB 8
`define ASIS_STAT_SEL_MSB 9
`define ASIS_ADDR_W 8
`endif

// ### verilog/asis_step_counter.v
// walks the sample steps of sequence zero from step one to the last step
`timescale 1ns/1ps
`include "asis_map.vh"
module asis_step_counter (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    input wire [`ASIS_STEP_W-1:0] last_i,
    output reg busy_o,
    output reg [`ASIS_STEP_W-1:0] step_o
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    reg state_ff;
    reg nxt_state;
    reg [`ASIS_STEP_W-1:0] nxt_step;
    // one step per clock; a start while running is ignored
    always @* begin
        nxt_state = state_ff;
        nxt_step = step_o;
        case (state_ff)
            ST_IDLE: begin
                if (start_i) begin
                    nxt_state = ST_RUN;
                    nxt_step = `ASIS_STEP_FIRST;
                end
            end
            ST_RUN: begin
                if (step_o == last_i || step_o == `ASIS_STEP_LAST) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_step = step_o + 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            step_o <= `ASIS_STEP_FIRST;
            busy_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            step_o <= nxt_step;
            busy_o <= nxt_state;
        end
    end
endmodule // asis_step_counter

// ### verilog/asis_top.v
// sequence zero input select register with wishbone slave and step walker
// Overview of operation
// R1: step one converts the input named by bits 1:0.
// R2: step two converts the input named by bits 5:4.
// R3: step three converts the input named by bits 9:8.
// R4: step four converts the input named by bits 13:12.
// R5: step five converts the input named by bits 17:16.
// R6: step six converts the input named by bits 21:20.
// R7: step seven converts the input named by bits 25:24.
// R8: step eight converts the input named by bits 29:28.
// R9: a field value is the analog input number directly.
// R10: software keeps reserved pairs unchanged on read-modify-write.
// R11: fields reset to zero, read back; reserved pairs read zero, ignore writes.
`timescale 1ns/1ps
`include "asis_map.vh"
module asis_top (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`ASIS_ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    input wire step_valid_i,
    input wire [`ASIS_STEP_W-1:0] step_i,
    output reg [`ASIS_FIELD_W-1:0] step_input_select_o,
    output reg [`ASIS_FIELD_W-1:0] seq_input_select_o,
    output reg seq_busy_o
);
    reg [31:0] sequence0_input_select_ff;
    reg [`ASIS_STEP_W-1:0] last_step_ff;
    reg start_ff;
    reg step_valid_ff;
    wire [`ASIS_FIELD_W-1:0] ext_pin;
    wire [`ASIS_FIELD_W-1:0] seq_pin;
    wire seq_busy;
    wire [`ASIS_STEP_W-1:0] seq_step;
    wire req;
    wire hit;
    reg [31:0] nxt_select;
    reg [31:0] rd_data;
    integer i;

    // byte-lane write merge; only field bits are writable
    function [31:0] lane_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer b;
        begin
            lane_merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
                end
            end
            lane_merge = lane_merge & `ASIS_SELECT_WMASK; // R11
        end
    endfunction

    // address decode that picks ack or err for the bus answer; read mux and write paths compare the address themselves
    function is_mapped;
        input [`ASIS_ADDR_W-1:0] a;
        begin
            is_mapped = (a == `ASIS_OFS_SELECT) || (a == `ASIS_OFS_STEP_CTRL) || (a == `ASIS_OFS_STEP_STATUS);
        end
    endfunction

    // request is answered one cycle later; the ack gap stops double takes
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign hit = is_mapped(wb_adr_i);

    always @* begin
        nxt_select = sequence0_input_select_ff;
        if (req && wb_we_i && wb_adr_i == `ASIS_OFS_SELECT) begin
            nxt_select = lane_merge(sequence0_input_select_ff, wb_dat_i, wb_sel_i);
        end
    end

    // read mux; unused bits read zero
    always @* begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            `ASIS_OFS_SELECT: begin
                rd_data = sequence0_input_select_ff; // R11
            end
            `ASIS_OFS_STEP_CTRL: begin
                rd_data[`ASIS_CTRL_LAST_MSB:`ASIS_CTRL_LAST_LSB] = last_step_ff;
            end
            `ASIS_OFS_STEP_STATUS: begin
                rd_data[`ASIS_STAT_BUSY] = seq_busy;
                rd_data[`ASIS_STAT_STEP_MSB:`ASIS_STAT_STEP_LSB] = seq_step;
                rd_data[`ASIS_STAT_SEL_MSB:`ASIS_STAT_SEL_LSB] = seq_pin;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // register state and bus answer
    always @(posedge clk_i) begin
        if (rst_i) begin
            sequence0_input_select_ff <= `ASIS_SELECT_RESET; // R11
            last_step_ff <= `ASIS_STEP_LAST;
            start_ff <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            sequence0_input_select_ff <= nxt_select;
            start_ff <= 1'b0;
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            wb_dat_o <= (req && !wb_we_i) ? rd_data : 32'h0000_0000;
            if (req && wb_we_i && wb_adr_i == `ASIS_OFS_STEP_CTRL) begin
                if (wb_sel_i[0]) begin
                    start_ff <= wb_dat_i[`ASIS_CTRL_RUN];
                    last_step_ff <= wb_dat_i[`ASIS_CTRL_LAST_MSB:`ASIS_CTRL_LAST_LSB];
                end
            end
        end
    end

    // field for the step named by the sequencer port; steps one..eight
    asis_field_mux u_ext_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .select_i(sequence0_input_select_ff),
        .step_i(step_i),
        .pin_o(ext_pin)
    ); // R1 R2 R3 R4 R5 R6 R7 R8

    // internal walker, lets software run the sequence itself
    asis_step_counter u_walk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start_ff),
        .last_i(last_step_ff),
        .busy_o(seq_busy),
        .step_o(seq_step)
    );

    asis_field_mux u_seq_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .select_i(sequence0_input_select_ff),
        .step_i(seq_step),
        .pin_o(seq_pin)
    ); // R1 R2 R3 R4 R5 R6 R7 R8

    // outputs registered; step_input_select_o holds while no step is valid, seq_input_select_o follows every cycle
    // valid is delayed one stage so it lines up with the registered field of its own step
    always @(posedge clk_i) begin
        if (rst_i) begin
            step_valid_ff <= 1'b0;
            step_input_select_o <= {`ASIS_FIELD_W{1'b0}};
            seq_input_select_o <= {`ASIS_FIELD_W{1'b0}};
            seq_busy_o <= 1'b0;
        end else begin
            step_valid_ff <= step_valid_i;
            if (step_valid_ff) begin
                step_input_select_o <= ext_pin; // R9
            end
            seq_input_select_o <= seq_pin; // R9
            seq_busy_o <= seq_busy;
        end
    end
endmodule // asis_top
